// ---- design/asc_ctrl.sv ----
// Controller driving a 512K x 8 asynchronous static memory
//
// Contract
// [RQ1] Write strobe stays high through every read.
// [RQ2] Memory writes during overlap of select low and write strobe low.
// [RQ3] Strobe-ended write with output drive low lasts float plus data time.
// [RQ4] With output drive high, strobe low at least 8 ns.
// [RQ5] Select falling with or after strobe keeps memory outputs floating.
// [RQ6] Select held low at least 8 ns before write end.
// [RQ7] Controller never drives the bus while memory drives it.
// [RQ8] Address-late read data valid 10 ns after address.
// [RQ9] Memory holds old data 4 ns after address change.
// [RQ10] Read data valid 5 ns after output drive falls.
// [RQ11] Read data valid 10 ns after select falls.
// [RQ12] Memory floats within 5 ns after select rises.
// [RQ13] Memory floats within 6 ns after write strobe falls.
// [RQ14] Memory waits 3 ns after write end before driving.
// [RQ15] Write data valid at least 6 ns before write end.
// [RQ16] Address valid at least 8 ns before write end.
// [RQ17] Select high: memory ignores strobes, floats, standby.
// [RQ18] Nineteen address bits select one of 524288 bytes.
`timescale 1ns/100ps
module asc_ctrl (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // User request
  input  wire logic                        req,
  input  wire logic                        req_write,
  input  wire logic [asc_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic [asc_pkg::DATA_W-1:0]  req_wdata,
  output logic                             req_ready,
  // User answer
  output logic                             rsp_valid,
  output logic [asc_pkg::DATA_W-1:0]       rsp_rdata,
  // Memory pins
  output logic [asc_pkg::ADDR_W-1:0]       mem_addr,
  output logic                             mem_cs_n,
  output logic                             mem_we_n,
  output logic                             mem_oe_n,
  output logic [asc_pkg::DATA_W-1:0]       mem_dq_o,
  output logic                             mem_dq_oe,
  input  wire logic [asc_pkg::DATA_W-1:0]  mem_dq_i
);

  asc_pkg::asc_state_t state;
  asc_pkg::asc_state_t next_state;
  logic                is_write;
  logic [asc_pkg::DATA_W-1:0] dq_s1;
  logic [asc_pkg::DATA_W-1:0] dq_s2;

  asc_cnt_if cnt ();

  asc_timer u_timer (
    .clk (clk),
    .rst (rst),
    .cnt (cnt)
  );

  // Phase decode
  wire take     = (state == asc_pkg::ASC_IDLE) && req;
  wire in_setup = (state == asc_pkg::ASC_SETUP);
  wire in_write = (state == asc_pkg::ASC_WRITE);
  wire in_read  = (state == asc_pkg::ASC_READ);
  wire in_turn  = (state == asc_pkg::ASC_TURN);
  wire rd_done  = in_read && cnt.done;
  wire wr_done  = in_write && cnt.done;

  // Timer loads at each phase entry
  assign cnt.load  = take || in_setup || rd_done;
  assign cnt.value = in_setup ? (is_write ? asc_pkg::WR_CNT
                                          : asc_pkg::RD_CNT)
                   : (take ? 4'h0 : asc_pkg::TA_CNT);

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      asc_pkg::ASC_IDLE: begin
        if (req) begin
          next_state = asc_pkg::ASC_SETUP;
        end
      end
      asc_pkg::ASC_SETUP: begin
        next_state = is_write ? asc_pkg::ASC_WRITE : asc_pkg::ASC_READ;
      end
      asc_pkg::ASC_WRITE: begin
        if (cnt.done) begin
          next_state = asc_pkg::ASC_IDLE;
        end
      end
      asc_pkg::ASC_READ: begin
        if (cnt.done) begin
          next_state = asc_pkg::ASC_TURN;
        end
      end
      asc_pkg::ASC_TURN: begin
        if (cnt.done) begin
          next_state = asc_pkg::ASC_IDLE;
        end
      end
      default: begin
        next_state = asc_pkg::ASC_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= asc_pkg::ASC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Data pins pass two flops; the memory is asynchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dq_s1 <= mem_dq_i;
      dq_s2 <= dq_s1;
    end
  end

  // Address and data latched at request; held stable all cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      is_write <= 1'b0;
      mem_addr <= 19'h00000;
      mem_dq_o <= 8'h00;
    end else if (take) begin
      is_write <= req_write;
      mem_addr <= req_addr; // RQ16 RQ18
      mem_dq_o <= req_wdata; // RQ15
    end
  end

  // Strobes; address and data set up one cycle before strobes fall
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_cs_n  <= asc_pkg::CS_N_RST;
      mem_we_n  <= asc_pkg::WE_N_RST;
      mem_oe_n  <= asc_pkg::OE_N_RST;
      mem_dq_oe <= 1'b0;
    end else begin
      // Select and strobe fall together so memory outputs stay floating
      mem_cs_n  <= !((in_setup) || (in_write && !cnt.done) ||
                     (in_read && !cnt.done)); // RQ5 RQ6 RQ17
      // Strobe high throughout reads; low span counted by timer
      mem_we_n  <= !((in_setup && is_write) ||
                     (in_write && !cnt.done)); // RQ1 RQ2 RQ3 RQ4
      // Output drive never low during a write
      mem_oe_n  <= !((in_setup && !is_write) ||
                     (in_read && !cnt.done)); // RQ1
      // Drive bus only in writes, from setup while output drive is high
      mem_dq_oe <= (take && req_write) ||
                   (in_setup && is_write) || (in_write && !cnt.done); // RQ7
    end
  end

  // Read data taken after access time plus sync delay margin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
      req_ready <= 1'b0;
    end else begin
      rsp_valid <= rd_done || wr_done;
      if (rd_done) begin
        rsp_rdata <= dq_s2; // RQ8 RQ10 RQ11
      end
      // Ready only in idle; turn phase covers memory float time
      req_ready <= (next_state == asc_pkg::ASC_IDLE) && !take &&
                   !in_turn; // RQ12 RQ14
    end
  end

endmodule // asc_ctrl

// ---- common/asc_pkg.sv ----
// Package of constants and types for the asynchronous memory port controller
package asc_pkg;

  // Clock rate in kHz and period in ns
  localparam int unsigned CLK_KHZ      = 10000;
  localparam int unsigned CLK_NS       = 1000000 / CLK_KHZ;

  // Widths of the memory port
  localparam int unsigned ADDR_W       = 19;
  localparam int unsigned DATA_W       = 8;

  // Timing figures in ns as printed
  localparam int unsigned T_WP_NS      = 8;
  localparam int unsigned T_CW_NS      = 8;
  localparam int unsigned T_AW_NS      = 8;
  localparam int unsigned T_DW_NS      = 6;
  localparam int unsigned T_WHZ_NS     = 6;
  localparam int unsigned T_AA_NS      = 10;
  localparam int unsigned T_OE_NS      = 5;
  localparam int unsigned T_HZ_NS      = 5;
  localparam int unsigned T_OW_NS      = 3;

  // Least times round up, none below one cycle
  function automatic int unsigned ceil_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Write strobe low: float plus data valid, the longer of this and tWP
  localparam int unsigned WR_CYC  =
    (ceil_cyc(T_WHZ_NS + T_DW_NS) > ceil_cyc(T_WP_NS)) ?
    ceil_cyc(T_WHZ_NS + T_DW_NS) : ceil_cyc(T_WP_NS);
  // Read wait before sampling: address access
  localparam int unsigned RD_CYC  = ceil_cyc(T_AA_NS);
  // Turnaround idle after a read before the bus is driven
  localparam int unsigned TA_CYC  = ceil_cyc(T_HZ_NS);
  // One more read wait so the sampled byte reaches the second sync flop
  localparam int unsigned SYNC_CYC = 1;

  localparam int unsigned CNT_W   = 4;
  localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_CYC);
  localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC + SYNC_CYC);
  localparam logic [CNT_W-1:0] TA_CNT = CNT_W'(TA_CYC);

  // Reset values of the strobes (all deasserted)
  localparam logic CS_N_RST = 1'b1;
  localparam logic WE_N_RST = 1'b1;
  localparam logic OE_N_RST = 1'b1;

  // Controller states
  typedef enum logic [2:0] {
    ASC_IDLE  = 3'b000,
    ASC_SETUP = 3'b001,
    ASC_WRITE = 3'b010,
    ASC_READ  = 3'b011,
    ASC_TURN  = 3'b100
  } asc_state_t;

endpackage

// ---- common/asc_cnt_if.sv ----
// Interface between controller and its cycle timer
`timescale 1ns/100ps
interface asc_cnt_if;
  logic                          load;
  logic [asc_pkg::CNT_W-1:0]     value;
  logic                          done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface

// ---- design/asc_timer.sv ----
// Down counter timing strobe phases
`timescale 1ns/100ps
module asc_timer (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Load and done
  asc_cnt_if.tmr    cnt
);

  logic [asc_pkg::CNT_W-1:0] count;
  logic [asc_pkg::CNT_W-1:0] next_count;

  // Done while count is zero
  assign cnt.done   = (count == '0);
  assign next_count = cnt.load ? cnt.value :
                      (cnt.done ? count : count - 4'h1);

  // Counter register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule // asc_timer

// ---- verification/asc_sram_model.sv ----
// Behavioural model of the asynchronous byte memory on the far side
`timescale 1ns/100ps
module asc_sram_model (
  // Memory pins
  input  wire logic [18:0] mem_addr,
  input  wire logic        mem_cs_n,
  input  wire logic        mem_we_n,
  input  wire logic        mem_oe_n,
  input  wire logic [7:0]  mem_dq_o,
  input  wire logic        mem_dq_oe,
  // Resolved bus level
  output logic      [7:0]  mem_dq_i
);
  logic [7:0] mem [logic [18:0]];
  logic [7:0] rd;
  logic       drv;
  // Drives only in a selected read, never during a write strobe
  assign drv = !mem_cs_n && !mem_oe_n && mem_we_n;
  // Data arrives one access time after the address settles
  always @(mem_addr or drv) begin
    rd <= #10 mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr[7:0];
  end
  // Store during the overlap of select and strobe
  always @(mem_cs_n, mem_we_n, mem_addr, mem_dq_o, mem_dq_oe) begin
    if (!mem_cs_n && !mem_we_n && mem_dq_oe)
      mem[mem_addr] = mem_dq_o;
  end
  // Released bus shows the inverse of its last level, not a stale value
  always @(mem_dq_oe, drv, rd, mem_dq_o) begin
    if (mem_dq_oe)
      mem_dq_i = mem_dq_o;
    else if (drv)
      mem_dq_i = rd;
    else
      mem_dq_i = ~mem_dq_i;
  end
endmodule // asc_sram_model

// ---- verification/asc_ctrl_checker.sv ----
// Checker of strobe and bus ownership at the memory pins
`timescale 1ns/100ps
module asc_ctrl_checker (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Memory pins
  input  wire logic [18:0] mem_addr,
  input  wire logic        mem_cs_n,
  input  wire logic        mem_we_n,
  input  wire logic        mem_oe_n,
  input  wire logic [7:0]  mem_dq_o,
  input  wire logic        mem_dq_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_read_we_high: assert property (!mem_oe_n |-> mem_we_n)
    else $error("write strobe low in a read");
  a_wr_oe_high: assert property ($fell(mem_we_n) |->
    mem_oe_n && $past(mem_dq_oe)) else $error("bad write start");
  a_wr_cs_low: assert property (!mem_we_n |-> !mem_cs_n)
    else $error("strobe low without select");
  a_wr_end_cs: assert property ($rose(mem_we_n) |-> !$past(mem_cs_n))
    else $error("select not held to write end");
  a_no_contend: assert property (!mem_cs_n && !mem_oe_n |-> !mem_dq_oe)
    else $error("bus driven in a read");
  a_turn_idle: assert property ($rose(mem_oe_n) |-> !mem_dq_oe [*2])
    else $error("bus driven too soon after a read");
  a_wr_data_hold: assert property (!mem_we_n && !$past(mem_we_n) |->
    $stable(mem_dq_o) && mem_dq_oe) else $error("write data moved");
  a_wr_addr_hold: assert property (!mem_we_n && !$past(mem_we_n) |->
    $stable(mem_addr)) else $error("address moved in a write");
endmodule // asc_ctrl_checker
bind asc_ctrl asc_ctrl_checker u_chk (.clk, .rst, .mem_addr, .mem_cs_n,
  .mem_we_n, .mem_oe_n, .mem_dq_o, .mem_dq_oe);

// ---- verification/async_sram_byte_port_tb.sv ----
// Self-checking bench of the memory port controller
`timescale 1ns/100ps
module async_sram_byte_port_tb;
  logic        clk, rst, req, req_write, req_ready, rsp_valid;
  logic [18:0] req_addr, mem_addr;
  logic [7:0]  req_wdata, rsp_rdata, mem_dq_o, mem_dq_i;
  logic        mem_cs_n, mem_we_n, mem_oe_n, mem_dq_oe;
  logic [7:0]  ref_mem [int];
  logic [18:0] corner [4] = '{19'h00000, 19'h7ffff, 19'h3ffff, 19'h40000};
  int          n_mismatch, checks_done, cyc, seed, i, a;
  int          addr_q[$];
  asc_ctrl uut (.*);
  asc_sram_model u_mem (.*);
  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input logic [18:0] seen, input logic [18:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // One transfer; bounded waits so a hang is caught here
  task automatic op(input logic wr, input logic [18:0] ad, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    req = 1'b1;
    req_write = wr;
    req_addr = ad;
    req_wdata = d;
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(rsp_valid, 1'b1);
    if (wr)
      ref_mem[ad] = d;
    else
      check(rsp_rdata, ref_mem[ad]);
  endtask
  // Cycle ceiling against a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    seed = 1397;
    {req, req_write, req_addr, req_wdata} = '0;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    check(mem_cs_n, 1'b1);
    check(mem_dq_oe, 1'b0);
    check(req_ready, 1'b0);
    rst = 1'b0;
    @(negedge clk);
    check(req_ready, 1'b1);
    $display("test reset done");
    // Ends of the space and the top address bit kept apart
    for (i = 0; i < 8; i++)
      op(i < 4, corner[i%4], corner[i%4][7:0] ^ 8'h5a);
    $display("test corners done");
    // Mixed random traffic back to back
    for (i = 0; i < 40; i++) begin
      a = $random(seed);
      if (i < 4 || a[0]) begin
        a = {$random(seed)} % 19'h7fff0;
        addr_q.push_back(a);
        op(1'b1, a[18:0], 8'($random(seed)));
      end else begin
        a = addr_q[{$random(seed)} % addr_q.size()];
        op(1'b0, a[18:0], 8'h00);
      end
    end
    $display("test random done");
    // Reset in mid write lets go of the bus and strobes
    op(1'b1, 19'h7fff5, 8'h00);
    req = 1'b1;
    @(negedge clk);
    req = 1'b0;
    @(negedge clk);
    check(mem_we_n, 1'b0);
    rst = 1'b1;
    @(negedge clk);
    check(mem_we_n, 1'b1);
    check(mem_dq_oe, 1'b0);
    rst = 1'b0;
    @(negedge clk);
    check(req_ready, 1'b1);
    op(1'b0, corner[1], 8'h00);
    $display("test mid reset done");
    conclude();
  end
endmodule // async_sram_byte_port_tb
